// ---- design/carrier_timer_pair.sv ----
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module carrier_timer_pair (
  input wire logic core_clk, // System clock, 125 MHz.
  input wire logic srst, // Power-on reset, synchronous, active high.
  input wire logic stop_recover, // Stop-mode recovery, one-cycle pulse.
  input wire logic hsel, // AHB slave select.
  input wire logic [31:0] haddr, // AHB address.
  input wire logic [1:0] htrans, // AHB transfer type.
  input wire logic hwrite, // AHB write.
  input wire logic [2:0] hsize, // AHB size, word only.
  input wire logic [31:0] hwdata, // AHB write data.
  input wire logic hready, // AHB bus ready.
  output logic hreadyout, // Never stalls.
  output logic hresp, // Always OKAY.
  output logic [31:0] hrdata, // AHB read data.
  input wire logic carrier_in, // Carrier edge input.
  input wire logic port_out_value, // Plain port output value.
  output logic counter8_output_pin, // Pin shared with port output.
  output logic counter16_output, // Wide counter output.
  output logic counter8_irq, // Narrow counter interrupt pulse.
  output logic counter16_irq // Wide counter interrupt pulse.
);
  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_pend;
  logic [7:0] wr_idx;
  logic [7:0] rd_val;
  logic [15:0] rd_wide;
  logic acc;
  logic wr_ctrl8, wr_shared, wr_ctrl16;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && htrans[1] && hready && (hsize == 3'h2);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
    end else if (hready) begin
      wr_pend <= acc && hwrite;
      wr_idx <= haddr[9:2];
    end
  end

  assign wr_ctrl8 = wr_pend && (wr_idx == carrier_timer_pkg::IDX_CTRL8);
  assign wr_shared = wr_pend && (wr_idx == carrier_timer_pkg::IDX_SHARED);
  assign wr_ctrl16 = wr_pend && (wr_idx == carrier_timer_pkg::IDX_CTRL16);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic run8, oneshot8, tout8, capmask8, tomask8, route8;
  logic run16, mode16, tout16, capmask16, tomask16;
  logic [1:0] pre_sel, edge_sel, pp_sel;
  logic demod, lvl8, lvl16, rflag, fflag;
  logic [7:0] low8, high8, low16, high16, rcap, fcap;
  logic [15:0] cap16;
  logic clr_tout8, clr_tout16, clr_rflag, clr_fflag;
  logic tick, rise_ev, fall_ev, qual_ev, pp_on;
  logic t8_term, t16_term, cap8_ev, cap16_ev;
  logic pp_to16, pp_to8, stop8, stop16;
  logic mode16_rise;
  carrier_timer_pkg::count_state_e st8, st16;
  logic [7:0] cnt8;
  logic [15:0] cnt16;
  logic out8, out16, recap_arm;

  assign pp_on = (pp_sel != 2'h0) && !demod;
  assign mode16_rise = wr_ctrl16 && hwdata[carrier_timer_pkg::B_ONESHOT] && !mode16;

  // Fields that a stop-mode recovery leaves alone.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pre_sel <= 2'h0;
      capmask8 <= 1'b0;
      tomask8 <= 1'b0;
    end else if (wr_ctrl8) begin
      pre_sel <= hwdata[carrier_timer_pkg::B_PRE +: 2];
      capmask8 <= hwdata[carrier_timer_pkg::B_CAPMASK];
      tomask8 <= hwdata[carrier_timer_pkg::B_TOMASK];
    end
  end

  // Fields that a stop-mode recovery clears.
  always_ff @(posedge core_clk) begin
    if (srst || stop_recover) begin
      oneshot8 <= 1'b0;
      route8 <= 1'b0;
    end else if (wr_ctrl8) begin
      oneshot8 <= hwdata[carrier_timer_pkg::B_ONESHOT];
      route8 <= hwdata[carrier_timer_pkg::B_ROUTE];
    end
  end

  // Run bits: hardware hands over between counters in ping-pong.
  always_ff @(posedge core_clk) begin
    if (srst || stop_recover) begin
      run8 <= 1'b0;
      run16 <= 1'b0;
    end else begin
      if (wr_ctrl8) begin
        run8 <= hwdata[carrier_timer_pkg::B_RUN];
      end else if (pp_to16 || stop8) begin
        run8 <= 1'b0;
      end else if (pp_to8) begin
        run8 <= 1'b1;
      end
      if (wr_ctrl16) begin
        run16 <= hwdata[carrier_timer_pkg::B_RUN];
      end else if (pp_to8 || stop16) begin
        run16 <= 1'b0;
      end else if (pp_to16) begin
        run16 <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode16 <= 1'b0;
      capmask16 <= 1'b0;
      tomask16 <= 1'b0;
      demod <= 1'b0;
      edge_sel <= 2'h0;
      pp_sel <= 2'h0;
      lvl8 <= 1'b0;
      lvl16 <= 1'b0;
    end else begin
      if (wr_ctrl16) begin
        mode16 <= hwdata[carrier_timer_pkg::B_ONESHOT];
        capmask16 <= hwdata[carrier_timer_pkg::B_CAPMASK];
        tomask16 <= hwdata[carrier_timer_pkg::B_TOMASK];
      end
      if (wr_shared) begin
        demod <= hwdata[carrier_timer_pkg::B_DEMOD];
        edge_sel <= hwdata[carrier_timer_pkg::B_EDGE +: 2];
        pp_sel <= hwdata[carrier_timer_pkg::B_PP +: 2];
        lvl8 <= hwdata[carrier_timer_pkg::B_LVL8];
        lvl16 <= hwdata[carrier_timer_pkg::B_LVL16];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      low8 <= 8'h00;
      high8 <= 8'h00;
      low16 <= 8'h00;
      high16 <= 8'h00;
    end else if (wr_pend) begin
      if (wr_idx == carrier_timer_pkg::IDX_LOW8) low8 <= hwdata[7:0];
      if (wr_idx == carrier_timer_pkg::IDX_HIGH8) high8 <= hwdata[7:0];
      if (wr_idx == carrier_timer_pkg::IDX_LOW16) low16 <= hwdata[7:0];
      if (wr_idx == carrier_timer_pkg::IDX_HIGH16) high16 <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // A write of one only requests the clear; it lands on the next tick,
  // so a stop and a clear in one write would race the counter.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clr_tout8 <= 1'b0;
      clr_tout16 <= 1'b0;
      clr_rflag <= 1'b0;
      clr_fflag <= 1'b0;
    end else begin
      clr_tout8 <= (clr_tout8 && !tick) || (wr_ctrl8 && hwdata[carrier_timer_pkg::B_TOUT]);
      clr_tout16 <= (clr_tout16 && !tick) || (wr_ctrl16 && hwdata[carrier_timer_pkg::B_TOUT]);
      clr_rflag <= (clr_rflag && !tick) || (wr_shared && hwdata[carrier_timer_pkg::B_LVL8]);
      clr_fflag <= (clr_fflag && !tick) || (wr_shared && hwdata[carrier_timer_pkg::B_LVL16]);
    end
  end

  // Hardware set wins over a clear landing in the same cycle.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tout8 <= 1'b0;
      tout16 <= 1'b0;
      rflag <= 1'b0;
      fflag <= 1'b0;
    end else begin
      tout8 <= t8_term || (tout8 && !(clr_tout8 && tick));
      tout16 <= t16_term || (tout16 && !(clr_tout16 && tick));
      rflag <= (cap8_ev && rise_ev) || (rflag && !(clr_rflag && tick));
      fflag <= (cap8_ev && fall_ev) || (fflag && !(clr_fflag && tick));
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      counter8_irq <= 1'b0;
      counter16_irq <= 1'b0;
    end else begin
      counter8_irq <= (cap8_ev && capmask8) || (t8_term && tomask8);
      counter16_irq <= (cap16_ev && capmask16) || (t16_term && tomask16);
    end
  end

  // ----------------------------------------------------------------
  // Timebase and edges
  // ----------------------------------------------------------------
  prescale_divider #(.WIDTH(carrier_timer_pkg::PRE_WIDTH)) u_div (
    .core_clk(core_clk),
    .srst(srst),
    .sel(pre_sel),
    .tick(tick)
  );

  edge_qualifier u_edge (
    .core_clk(core_clk),
    .srst(srst),
    .sig(carrier_in),
    .sel(edge_sel),
    .rise(rise_ev),
    .fall(fall_ev),
    .qual(qual_ev)
  );

  // ----------------------------------------------------------------
  // Narrow counter
  // ----------------------------------------------------------------
  assign t8_term = tick && (st8 == carrier_timer_pkg::ST_COUNT) && run8 && (cnt8 == 8'h00);
  assign cap8_ev = demod && run8 && (st8 == carrier_timer_pkg::ST_COUNT) && qual_ev;
  assign pp_to16 = t8_term && pp_on;
  assign stop8 = t8_term && !demod && !pp_on && oneshot8;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st8 <= carrier_timer_pkg::ST_IDLE;
      cnt8 <= 8'h00;
      out8 <= 1'b0;
      rcap <= 8'h00;
      fcap <= 8'h00;
    end else begin
      case (st8)
        carrier_timer_pkg::ST_IDLE: begin
          if (run8 && demod) begin
            st8 <= carrier_timer_pkg::ST_ARMED;
          end else if (run8 && tick) begin
            out8 <= lvl8;
            cnt8 <= lvl8 ? high8 : low8;
            st8 <= carrier_timer_pkg::ST_COUNT;
          end
        end
        carrier_timer_pkg::ST_ARMED: begin
          if (!run8) begin
            st8 <= carrier_timer_pkg::ST_IDLE;
          end else if (qual_ev) begin
            cnt8 <= carrier_timer_pkg::ONES8;
            st8 <= carrier_timer_pkg::ST_COUNT;
          end
        end
        carrier_timer_pkg::ST_COUNT: begin
          if (cap8_ev && run8) begin
            if (rise_ev) rcap <= ~cnt8;
            else fcap <= ~cnt8;
            cnt8 <= carrier_timer_pkg::ONES8;
          end else if (tick) begin
            if (!run8) begin
              st8 <= carrier_timer_pkg::ST_IDLE;
            end else if (cnt8 != 8'h00) begin
              cnt8 <= cnt8 - 8'h01;
            end else if (demod) begin
              cnt8 <= carrier_timer_pkg::ONES8;
            end else if (pp_on || oneshot8) begin
              st8 <= carrier_timer_pkg::ST_IDLE;
            end else begin
              out8 <= ~out8;
              cnt8 <= out8 ? low8 : high8;
            end
          end
        end
        default: st8 <= carrier_timer_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Wide counter
  // ----------------------------------------------------------------
  assign t16_term = tick && (st16 == carrier_timer_pkg::ST_COUNT) && run16 && (cnt16 == 16'h0000);
  assign pp_to8 = t16_term && pp_on;
  assign stop16 = t16_term && !demod && !pp_on && mode16;
  assign cap16_ev = demod && (st16 == carrier_timer_pkg::ST_COUNT) && run16 &&
                    ((qual_ev && (!mode16 || recap_arm)) || (mode16 && t8_term));

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st16 <= carrier_timer_pkg::ST_IDLE;
      cnt16 <= 16'h0000;
      out16 <= 1'b0;
      cap16 <= 16'h0000;
      recap_arm <= 1'b0;
    end else begin
      if (mode16_rise) begin
        recap_arm <= 1'b1;
      end else if (cap16_ev && qual_ev) begin
        recap_arm <= 1'b0;
      end
      case (st16)
        carrier_timer_pkg::ST_IDLE: begin
          if (run16 && demod) begin
            st16 <= carrier_timer_pkg::ST_ARMED;
          end else if (run16 && tick) begin
            out16 <= lvl16;
            cnt16 <= {high16, low16};
            st16 <= carrier_timer_pkg::ST_COUNT;
          end
        end
        carrier_timer_pkg::ST_ARMED: begin
          if (!run16) begin
            st16 <= carrier_timer_pkg::ST_IDLE;
          end else if (qual_ev) begin
            cnt16 <= {high16, low16};
            recap_arm <= 1'b0;
            st16 <= carrier_timer_pkg::ST_COUNT;
          end
        end
        carrier_timer_pkg::ST_COUNT: begin
          if (cap16_ev && qual_ev) begin
            cap16 <= cnt16;
            cnt16 <= {high16, low16};
          end else begin
            if (cap16_ev) begin
              cap16 <= cnt16;
            end
            if (tick) begin
              if (!run16) begin
                st16 <= carrier_timer_pkg::ST_IDLE;
              end else if (cnt16 != 16'h0000) begin
                cnt16 <= cnt16 - 16'h0001;
              end else if (demod) begin
                cnt16 <= carrier_timer_pkg::ONES16;
              end else if (pp_on || mode16) begin
                st16 <= carrier_timer_pkg::ST_IDLE;
              end else begin
                out16 <= ~out16;
                cnt16 <= {high16, low16};
              end
            end
          end
        end
        default: st16 <= carrier_timer_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb begin
    counter8_output_pin = route8 ? out8 : port_out_value;
    counter16_output = out16;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    rd_wide = 16'h0000;
    case (haddr[9:2])
      carrier_timer_pkg::IDX_CTRL8:
        rd_val = {run8, oneshot8, tout8, pre_sel, capmask8, tomask8, route8};
      carrier_timer_pkg::IDX_SHARED:
        rd_val = {1'b0, demod, edge_sel, pp_sel,
                  demod ? rflag : lvl8, demod ? fflag : lvl16};
      carrier_timer_pkg::IDX_CTRL16:
        rd_val = {run16, mode16, tout16, 2'h0, capmask16, tomask16, 1'b0};
      carrier_timer_pkg::IDX_LOW8: rd_val = low8;
      carrier_timer_pkg::IDX_HIGH8: rd_val = high8;
      carrier_timer_pkg::IDX_LOW16: rd_val = low16;
      carrier_timer_pkg::IDX_HIGH16: rd_val = high16;
      carrier_timer_pkg::IDX_RCAP: rd_val = rcap;
      carrier_timer_pkg::IDX_FCAP: rd_val = fcap;
      carrier_timer_pkg::IDX_CAP16: rd_wide = cap16;
      default: rd_val = 8'h00;
    endcase
  end

  // Unmapped offsets read zero; upper address bits are not decoded.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= {16'h0000, rd_wide | {8'h00, rd_val}};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_por_clears: assert property (@(posedge core_clk) srst |=>
    (!run8 && pre_sel == 2'h0 && !tout8 && !route8))
    else $error("Control not cleared by reset.");
  a_recover_keeps: assert property (@(posedge core_clk) disable iff (srst)
    (stop_recover && !wr_ctrl8) |=> (!run8 && pre_sel == $past(pre_sel) && !route8))
    else $error("Recovery handled control fields wrongly.");
  a_timeout_sets: assert property (@(posedge core_clk) disable iff (srst)
    t8_term |=> tout8)
    else $error("Timeout flag not set at zero.");
  a_flag_holds: assert property (@(posedge core_clk) disable iff (srst)
    (tout8 && !clr_tout8) |=> tout8)
    else $error("Timeout flag cleared without request.");
  a_first_edge: assert property (@(posedge core_clk) disable iff (srst)
    (st8 == carrier_timer_pkg::ST_ARMED && run8 && qual_ev) |=>
    (st8 == carrier_timer_pkg::ST_COUNT && cnt8 == 8'hFF))
    else $error("Counting did not start at first edge.");
  a_capture_cpl: assert property (@(posedge core_clk) disable iff (srst)
    (cap8_ev && run8 && rise_ev) |=> (rcap == ~$past(cnt8) && cnt8 == 8'hFF && rflag))
    else $error("Rising capture or reload wrong.");
  a_wide_wrap: assert property (@(posedge core_clk) disable iff (srst)
    (t16_term && demod && !cap16_ev) |=> (cnt16 == 16'hFFFF && tout16))
    else $error("Wide counter did not wrap.");
  a_hold_capture: assert property (@(posedge core_clk) disable iff (srst)
    (cap16_ev && !qual_ev) |=> (cap16 == $past(cnt16)))
    else $error("Wide capture on timeout wrong.");
  a_pp_handoff: assert property (@(posedge core_clk) disable iff (srst)
    (pp_to16 && !wr_ctrl8 && !wr_ctrl16 && !stop_recover) |=> (!run8 && run16))
    else $error("Ping-pong did not hand over.");
  a_pp_return: assert property (@(posedge core_clk) disable iff (srst)
    (pp_to8 && !wr_ctrl8 && !wr_ctrl16 && !stop_recover) |=> (run8 && !run16))
    else $error("Ping-pong did not hand back.");
endmodule

// ---- design/carrier_timer_pkg.sv ----
package carrier_timer_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_CTRL8 = 8'h00;
  localparam logic [7:0] IDX_SHARED = 8'h01;
  localparam logic [7:0] IDX_CTRL16 = 8'h02;
  localparam logic [7:0] IDX_LOW8 = 8'h04;
  localparam logic [7:0] IDX_HIGH8 = 8'h05;
  localparam logic [7:0] IDX_LOW16 = 8'h06;
  localparam logic [7:0] IDX_HIGH16 = 8'h07;
  localparam logic [7:0] IDX_RCAP = 8'h08;
  localparam logic [7:0] IDX_FCAP = 8'h09;
  localparam logic [7:0] IDX_CAP16 = 8'h0A;
  // Control bit positions, shared by both counter control registers except B_PRE and B_ROUTE, which only the narrow one has.
  localparam int B_RUN = 7;
  localparam int B_ONESHOT = 6;
  localparam int B_TOUT = 5;
  localparam int B_PRE = 3;
  localparam int B_CAPMASK = 2;
  localparam int B_TOMASK = 1;
  localparam int B_ROUTE = 0;
  // Shared control bit positions.
  localparam int B_DEMOD = 6;
  localparam int B_EDGE = 4;
  localparam int B_PP = 2;
  localparam int B_LVL8 = 1;
  localparam int B_LVL16 = 0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [7:0] ONES8 = 8'hFF;
  localparam logic [15:0] ONES16 = 16'hFFFF;
  localparam int PRE_WIDTH = 3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_COUNT = 3'b100
  } count_state_e;
endpackage

// ---- design/prescale_divider.sv ----
`timescale 1ns/1ps
module prescale_divider #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic [1:0] sel, // Divide by 1, 2, 4 or 8.
  output logic tick // One-cycle counter enable.
);
  logic [WIDTH-1:0] div;
  logic [WIDTH-1:0] mask;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  // A tick whenever the selected low bits are all ones.
  always_comb begin
    mask = WIDTH'((1 << sel) - 1);
    tick = ((div & mask) == mask);
  end
endmodule

// ---- design/edge_qualifier.sv ----
`timescale 1ns/1ps
module edge_qualifier (
  input wire logic core_clk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic sig, // Carrier input, synchronous.
  input wire logic [1:0] sel, // Rising, falling or both.
  output logic rise, // Rising edge seen.
  output logic fall, // Falling edge seen.
  output logic qual // Edge of a selected polarity.
);
  logic prev;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev <= 1'b0;
    end else begin
      prev <= sig;
    end
  end

  always_comb begin
    rise = sig & ~prev;
    fall = ~sig & prev;
    qual = (rise & sel[0]) | (fall & sel[1]);
  end
endmodule

// ---- bench/carrier_source.sv ----
`timescale 1ns/1ps
module carrier_source (
  input wire logic core_clk, // System clock.
  input wire logic enable, // Burst active.
  input wire logic [7:0] half, // Half period in cycles.
  output logic carrier // Carrier to the edge input.
);
  logic [7:0] cnt;
  initial begin
    carrier = 1'b0;
    cnt = 8'h00;
  end
  // The line stands still between bursts, as a real carrier would.
  always @(posedge core_clk) begin
    if (!enable) begin
      cnt <= 8'h00;
    end else if (cnt == half - 8'h01) begin
      cnt <= 8'h00;
      carrier <= ~carrier;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// ---- bench/carrier_timer_pair_test.sv ----
`timescale 1ns/1ps
module carrier_timer_pair_test;
  logic core_clk = 1'b0, srst = 1'b1, stop_recover = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic hready = 1'b1, port_out_value = 1'b0, car_en = 1'b0, carrier_in;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'h584D4ED6;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] car_half = 8'h0A, h;
  logic [15:0] w;
  logic hreadyout, hresp, pin, out16, irq8, irq16;
  int fails = 0, comparisons = 0, cycles = 0, last8 = 0, per8 = 0, n8 = 0, gap16 = 0;

  always #4 core_clk = ~core_clk;

  carrier_timer_pair i_dut (.core_clk(core_clk), .srst(srst), .stop_recover(stop_recover),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .carrier_in(carrier_in), .port_out_value(port_out_value), .counter8_output_pin(pin),
    .counter16_output(out16), .counter8_irq(irq8), .counter16_irq(irq16));

  carrier_source i_src (.core_clk(core_clk), .enable(car_en), .half(car_half),
    .carrier(carrier_in));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  // The edge cycle loads all ones, so one tick less than the half period is counted.
  function automatic logic [31:0] cap_expect(input logic [7:0] half);
    return {24'h0, half - 8'h01};
  endfunction

  // A one-shot pass costs its load cycle plus one tick per count, zero included.
  function automatic int run_len(input logic [15:0] v);
    return v + 2;
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, ad(idx), d, r);
  endtask

  task automatic chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, ad(idx), 32'h0, r);
    cmp(r, exp);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // A hang is cut short well past the few thousand cycles the tests need.
  always @(posedge core_clk) begin
    cycles++;
    if (irq8 === 1'b1) begin
      per8 = cycles - last8;
      last8 = cycles;
      n8++;
    end
    if (irq16 === 1'b1) begin
      gap16 = cycles - last8;
    end
    if (cycles == 60000) begin
      fails++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    wait_cycles(6);
    srst <= 1'b0;
    wait_cycles(1);
    chk(carrier_timer_pkg::IDX_CTRL8, 32'h0);
    chk(carrier_timer_pkg::IDX_SHARED, 32'h0);
    chk(carrier_timer_pkg::IDX_CTRL16, 32'h0);
    cmp({31'h0, hresp}, 32'h0);
    cmp({31'h0, pin}, {31'h0, port_out_value});
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(carrier_timer_pkg::IDX_LOW8, {24'h0, seed[7:0]});
      wr(carrier_timer_pkg::IDX_HIGH8, {24'h0, seed[15:8]});
      chk(carrier_timer_pkg::IDX_LOW8, {24'h0, seed[7:0]});
      chk(carrier_timer_pkg::IDX_HIGH8, {24'h0, seed[15:8]});
    end
    xfer(1'b0, 32'h3C, 32'h0, r);
    cmp(r, 32'h0);
    $display("test reset_and_holds done");
    wr(carrier_timer_pkg::IDX_CTRL8, 32'h5F);
    chk(carrier_timer_pkg::IDX_CTRL8, 32'h5F);
    port_out_value <= seed[16];
    stop_recover <= 1'b1;
    wait_cycles(1);
    stop_recover <= 1'b0;
    wait_cycles(1);
    chk(carrier_timer_pkg::IDX_CTRL8, 32'h1E);
    cmp({31'h0, pin}, {31'h0, port_out_value});
    $display("test recovery done");
    // Both holds equal, so the period does not depend on the output level.
    for (int p = 0; p < 4; p++) begin
      seed = lfsr(seed);
      h = 8'h03 + {5'h0, seed[2:0]};
      wr(carrier_timer_pkg::IDX_LOW8, {24'h0, h});
      wr(carrier_timer_pkg::IDX_HIGH8, {24'h0, h});
      wr(carrier_timer_pkg::IDX_CTRL8, 32'h82 | (p << 3));
      wait_cycles(((h + 1) << p) * 3 + 10);
      cmp(per8, (h + 1) << p);
      wr(carrier_timer_pkg::IDX_CTRL8, 32'h02 | (p << 3));
      chk(carrier_timer_pkg::IDX_CTRL8, 32'h22 | (p << 3));
      wr(carrier_timer_pkg::IDX_CTRL8, 32'h20);
      wait_cycles(2);
      chk(carrier_timer_pkg::IDX_CTRL8, 32'h0);
    end
    $display("test prescale_timeout done");
    wr(carrier_timer_pkg::IDX_LOW8, 32'hFF);
    wr(carrier_timer_pkg::IDX_HIGH8, 32'hFF);
    wr(carrier_timer_pkg::IDX_SHARED, 32'h70);
    wr(carrier_timer_pkg::IDX_CTRL8, 32'h84);
    seed = lfsr(seed);
    h = 8'h08 + {4'h0, seed[3:0]};
    car_half <= h;
    n8 = 0;
    car_en <= 1'b1;
    wait_cycles(h * 4 + h / 2);
    car_en <= 1'b0;
    wait_cycles(4);
    cmp(n8, 3);
    chk(carrier_timer_pkg::IDX_RCAP, cap_expect(h));
    chk(carrier_timer_pkg::IDX_FCAP, cap_expect(h));
    chk(carrier_timer_pkg::IDX_SHARED, 32'h73);
    $display("test demodulation done");
    // Stop first, clear flags in a later write, then set up ping-pong.
    wr(carrier_timer_pkg::IDX_CTRL8, 32'h00);
    wr(carrier_timer_pkg::IDX_SHARED, 32'h03);
    wr(carrier_timer_pkg::IDX_CTRL8, 32'h20);
    seed = lfsr(seed);
    h = 8'h02 + {4'h0, seed[3:0]};
    w = {7'h0, seed[16], seed[15:8]};
    wr(carrier_timer_pkg::IDX_HIGH8, {24'h0, h});
    wr(carrier_timer_pkg::IDX_LOW8, 32'h01);
    wr(carrier_timer_pkg::IDX_LOW16, {24'h0, w[7:0]});
    wr(carrier_timer_pkg::IDX_HIGH16, {24'h0, w[15:8]});
    wr(carrier_timer_pkg::IDX_CTRL16, 32'h42);
    wr(carrier_timer_pkg::IDX_SHARED, 32'h0F);
    wr(carrier_timer_pkg::IDX_CTRL8, 32'hC3);
    wait_cycles(3 * (run_len({8'h00, h}) + run_len(w)) + 10);
    cmp(per8, run_len({8'h00, h}) + run_len(w));
    cmp(gap16, run_len(w));
    cmp({31'h0, pin}, 32'h1);
    cmp({31'h0, out16}, 32'h1);
    wr(carrier_timer_pkg::IDX_SHARED, 32'h00);
    wr(carrier_timer_pkg::IDX_CTRL16, 32'h02);
    chk(carrier_timer_pkg::IDX_CTRL16, 32'h22);
    $display("test ping_pong done");
    print_verdict();
  end
endmodule
